/* rtl/ics_pkg.sv */
// package for the interrupt and advance-clock sequencer
package ics_pkg;
    localparam int          ICS_WORD_W     = 48;
    localparam int          ICS_ADDR_W     = 15;
    localparam logic [14:0] ICS_TRAP_BASE  = 15'h0007;
    localparam logic [14:0] ICS_TRAP_LAST  = 15'h000F;
    localparam logic [14:0] ICS_CLOCK_ADDR = 15'h0000;
    localparam logic [5:0]  ICS_FC_ADVCLK  = 6'h3F;
    localparam logic [5:0]  ICS_FC_37      = 6'h1F;
    // register byte addresses
    localparam logic [7:0]  ICS_REG_CTRL   = 8'h00;
    localparam logic [7:0]  ICS_REG_STAT   = 8'h04;
    localparam logic [7:0]  ICS_REG_PADDR  = 8'h08;
    localparam logic [7:0]  ICS_REG_ACC    = 8'h0C;
    localparam logic [7:0]  ICS_REG_QREG   = 8'h10;
    localparam logic [7:0]  ICS_REG_INSTR  = 8'h14;
    localparam logic [7:0]  ICS_REG_XCHG   = 8'h18;
    localparam logic [31:0] ICS_CTRL_RST   = 32'h0000_0000;
    localparam logic [1:0]  ICS_RESP_OKAY  = 2'h0;
    localparam logic [1:0]  ICS_RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'h0,
        ST_ENTRY = 4'h1,
        ST_SAVE  = 4'h2,
        ST_TRAPR = 4'h3,
        ST_TRAPW = 4'h4,
        ST_EXIT  = 4'h5,
        ST_CRD   = 4'h6,
        ST_CWAIT = 4'h7,
        ST_CADD  = 4'h8,
        ST_CWR   = 4'h9,
        ST_CEND  = 4'hA
    } ics_state_e;

    typedef struct packed {
        logic        req;
        logic        wr;
        logic [14:0] addr;
        logic [47:0] wdata;
        logic [47:0] wmask;
    } ics_mem_req_s;
endpackage

/* rtl/ics_sequencer.sv */
// interrupt and advance-clock control sequencer with axi4-lite registers
// Contract
// RULE_01 - enter interrupt sequence on pending interrupt, also during fetch or search
// RULE_02 - record internal or external type unless advance clock
// RULE_03 - not clock: copy program address to exchange low, clear control flops
// RULE_04 - load program address with trap 7 to 17 octal by type
// RULE_05 - set lockout blocking interrupts until jump back to trap upper half
// RULE_06 - clear all external requests when external interrupt present
// RULE_07 - reset internal request; pending requests wait for lockout clear
// RULE_08 - interrupt exit flop copies the half word exit flop
// RULE_09 - start storage read of trap location at program address
// RULE_10 - clear internal request flop, then set write operand wait storage
// RULE_11 - set return jump flop during interrupt sequence
// RULE_12 - clear interrupt-or-clock request after storage initiation
// RULE_13 - interrupted address into exchange upper, written into trap upper field only
// RULE_14 - trap word to instruction register, then always half exit to lower
// RULE_15 - clock request sets action, slave, advance flops and combined request
// RULE_16 - clock: complement exit flop then enter read operand
// RULE_17 - clock operand address is zero; read location zero
// RULE_18 - save accumulator into Q, restore it at end
// RULE_19 - exchange forced plus one into cleared accumulator, add word zero
// RULE_20 - sum to exchange, write back into location zero
// RULE_21 - set function code flop 00+77 for advance clock
// RULE_22 - clear clock wait, request, slave; set function 37 flop
`timescale 1ns/100ps
module ics_sequencer
    import ics_pkg::*;
(
    // clock and reset
    input  wire logic                CLK,
    input  wire logic                RST,
    // interrupt sources
    input  wire logic                INT_REQ_INTERNAL,
    input  wire logic [3:0]          INT_REQ_EXTERNAL,
    input  wire logic                ADV_CLOCK_REQ,
    input  wire logic                FETCH_ACTIVE,
    input  wire logic                SEARCH_ACTIVE,
    input  wire logic                JUMP_TO_TRAP_UPPER,
    // core memory
    output ics_mem_req_s             MEM_REQ,
    input  wire logic                MEM_DONE,
    input  wire logic [47:0]         MEM_RDATA,
    // status
    output logic                     INTERRUPT_LOCKOUT,
    output logic                     HALF_EXIT,
    // axi4-lite slave
    input  wire logic [7:0]          S_AXI_AWADDR,
    input  wire logic                S_AXI_AWVALID,
    output logic                     S_AXI_AWREADY,
    input  wire logic [31:0]         S_AXI_WDATA,
    input  wire logic [3:0]          S_AXI_WSTRB,
    input  wire logic                S_AXI_WVALID,
    output logic                     S_AXI_WREADY,
    output logic [1:0]               S_AXI_BRESP,
    output logic                     S_AXI_BVALID,
    input  wire logic                S_AXI_BREADY,
    input  wire logic [7:0]          S_AXI_ARADDR,
    input  wire logic                S_AXI_ARVALID,
    output logic                     S_AXI_ARREADY,
    output logic [31:0]              S_AXI_RDATA,
    output logic [1:0]               S_AXI_RRESP,
    output logic                     S_AXI_RVALID,
    input  wire logic                S_AXI_RREADY
);

    ics_state_e   state_r;
    logic [14:0]  prog_addr_r;
    logic [47:0]  xchg_r;
    logic [47:0]  acc_r;
    logic [47:0]  q_r;
    logic [47:0]  instruction_holding_reg;
    logic         interrupt_lockout_ff;
    logic         interrupt_exit_ff;
    logic         return_jump_ff;
    logic         interrupt_or_clock_request_ff;
    logic         clock_action_request_ff;
    logic         clock_request_slave_ff;
    logic         clock_wait_ff;
    logic         internal_request_ff;
    logic         half_word_exit_ff;
    logic         force_plus_one_ff;
    logic         function_37_ff;
    logic         advance_clock_function_ff;
    logic         adv_clock_ff;
    logic         int_internal_ff;
    logic         int_external_ff;
    logic         wo_wait_storage_ff;
    logic [3:0]   ext_pend_r;
    logic [3:0]   ext_s1_r;
    logic [3:0]   ext_s2_r;
    logic [3:0]   ext_s3_r;
    logic [3:0]   ext_lvl_r;
    logic [3:0]   ext_rise;
    logic [2:0]   int_s_r;
    logic [2:0]   clk_s_r;
    logic         int_edge;
    logic         clk_edge;
    logic         ext_any;
    logic         pending;
    ics_mem_req_s mem_r;
    logic [31:0]  ctrl_r;
    logic         aw_got_r;
    logic         w_got_r;
    logic [7:0]   awaddr_r;
    logic [31:0]  wdata_r;
    logic         clr_ext_pulse;

    function automatic logic [14:0] trap_addr(input logic internal, input logic [3:0] ext);
        logic [14:0] a;
        a = ICS_TRAP_BASE;
        if (!internal) begin
            a = ICS_TRAP_BASE + 15'h0001;
            for (int i = 0; i < 4; i++) begin
                if (ext[i] && a == ICS_TRAP_BASE + 15'h0001) begin
                    a = ICS_TRAP_BASE + 15'(2 * i + 2);
                end
            end
        end
        if (a > ICS_TRAP_LAST) begin
            a = ICS_TRAP_LAST;
        end
        return a;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // input synchronisers
    always_ff @(posedge CLK) begin
        if (RST) begin
            ext_s1_r <= 4'h0;
            ext_s2_r <= 4'h0;
            ext_s3_r <= 4'h0;
            int_s_r  <= 3'h0;
            clk_s_r  <= 3'h0;
        end else begin
            ext_s1_r <= INT_REQ_EXTERNAL;
            ext_s2_r <= ext_s1_r;
            ext_s3_r <= ext_s2_r;
            int_s_r  <= {int_s_r[1:0], INT_REQ_INTERNAL};
            clk_s_r  <= {clk_s_r[1:0], ADV_CLOCK_REQ};
        end
    end

    assign int_edge = int_s_r[1] & int_s_r[2];
    assign clk_edge = clk_s_r[1] & clk_s_r[2];
    assign ext_any  = |ext_pend_r;
    // a held request line counts once, so the sequence clear is not undone
    assign ext_rise = ext_s2_r & ext_s3_r & ~ext_lvl_r;
    // lockout blocks all interrupts; clock requests still pass
    assign pending  = !interrupt_lockout_ff && (internal_request_ff || ext_any); // RULE_05
    assign clr_ext_pulse = (state_r == ST_TRAPR) && int_external_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // request flops: set wins over clear
    always_ff @(posedge CLK) begin
        if (RST) begin
            ext_pend_r <= 4'h0;
            ext_lvl_r  <= 4'h0;
        end else begin
            ext_lvl_r  <= (ext_s2_r & ext_s3_r) | (ext_lvl_r & (ext_s2_r | ext_s3_r));
            ext_pend_r <= ext_rise |
                          (clr_ext_pulse ? 4'h0 : ext_pend_r); // RULE_06
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            internal_request_ff <= 1'b0;
        end else if (int_edge && !interrupt_lockout_ff) begin
            internal_request_ff <= 1'b1;
        end else if (state_r == ST_TRAPR && int_internal_ff) begin
            internal_request_ff <= 1'b0; // RULE_07 RULE_10
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            interrupt_lockout_ff <= 1'b0;
        end else if (state_r == ST_SAVE && !adv_clock_ff) begin
            interrupt_lockout_ff <= 1'b1; // RULE_05
        end else if (JUMP_TO_TRAP_UPPER) begin
            interrupt_lockout_ff <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            half_word_exit_ff <= 1'b0;
        end else if (state_r == ST_ENTRY && adv_clock_ff) begin
            half_word_exit_ff <= !half_word_exit_ff; // RULE_16
        end else if (state_r == ST_EXIT) begin
            half_word_exit_ff <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    always_ff @(posedge CLK) begin
        if (RST) begin
            state_r                       <= ST_IDLE;
            prog_addr_r                   <= 15'h0000;
            xchg_r                        <= 48'h0;
            acc_r                         <= 48'h0;
            q_r                           <= 48'h0;
            instruction_holding_reg       <= 48'h0;
            interrupt_exit_ff             <= 1'b0;
            return_jump_ff                <= 1'b0;
            interrupt_or_clock_request_ff <= 1'b0;
            clock_action_request_ff       <= 1'b0;
            clock_request_slave_ff        <= 1'b0;
            clock_wait_ff                 <= 1'b0;
            force_plus_one_ff             <= 1'b0;
            function_37_ff                <= 1'b0;
            advance_clock_function_ff     <= 1'b0;
            adv_clock_ff                  <= 1'b0;
            int_internal_ff               <= 1'b0;
            int_external_ff               <= 1'b0;
            wo_wait_storage_ff            <= 1'b0;
            mem_r                         <= '0;
        end else begin
            mem_r.req <= 1'b0;
            unique case (state_r)
                ST_IDLE: begin
                    function_37_ff <= 1'b0;
                    if (clk_edge && ctrl_r[0]) begin
                        clock_action_request_ff       <= 1'b1; // RULE_15
                        clock_request_slave_ff        <= 1'b1; // RULE_15
                        adv_clock_ff                  <= 1'b1; // RULE_15
                        clock_wait_ff                 <= 1'b1;
                        interrupt_or_clock_request_ff <= 1'b1; // RULE_15
                        state_r                       <= ST_ENTRY;
                    end else if (pending) begin
                        // fetch or search in progress does not hold off entry
                        interrupt_or_clock_request_ff <= 1'b1; // RULE_01
                        state_r                       <= ST_ENTRY;
                    end
                end
                ST_ENTRY: begin
                    xchg_r <= 48'h0;
                    if (!adv_clock_ff) begin
                        int_internal_ff <= internal_request_ff; // RULE_02
                        int_external_ff <= !internal_request_ff; // RULE_02
                        state_r         <= ST_SAVE;
                    end else begin
                        state_r <= ST_CRD;
                    end
                end
                ST_SAVE: begin
                    xchg_r[14:0]    <= prog_addr_r; // RULE_03
                    return_jump_ff  <= 1'b0; // RULE_03
                    force_plus_one_ff <= 1'b0; // RULE_03
                    prog_addr_r     <= trap_addr(int_internal_ff, ext_pend_r); // RULE_04
                    interrupt_exit_ff <= half_word_exit_ff; // RULE_08
                    state_r         <= ST_TRAPR;
                end
                ST_TRAPR: begin
                    mem_r.req  <= 1'b1; // RULE_09
                    mem_r.wr   <= 1'b0;
                    mem_r.addr <= prog_addr_r; // RULE_09
                    wo_wait_storage_ff <= 1'b1; // RULE_10
                    return_jump_ff     <= 1'b1; // RULE_11
                    interrupt_or_clock_request_ff <= 1'b0; // RULE_12
                    xchg_r[29:15] <= xchg_r[14:0]; // RULE_13
                    state_r <= ST_TRAPW;
                end
                ST_TRAPW: begin
                    if (MEM_DONE) begin
                        instruction_holding_reg <= MEM_RDATA; // RULE_14
                        mem_r.req   <= 1'b1;
                        mem_r.wr    <= 1'b1;
                        mem_r.wdata <= xchg_r;
                        mem_r.wmask <= 48'h0000_3FFF_8000; // RULE_13
                        int_internal_ff <= 1'b0;
                        int_external_ff <= 1'b0;
                        state_r <= ST_EXIT;
                    end
                end
                ST_EXIT: begin
                    if (MEM_DONE) begin
                        wo_wait_storage_ff <= 1'b0;
                        state_r <= ST_IDLE; // RULE_14
                    end
                end
                ST_CRD: begin
                    xchg_r[14:0]      <= prog_addr_r;
                    mem_r.req         <= 1'b1;
                    mem_r.wr          <= 1'b0;
                    mem_r.addr        <= ICS_CLOCK_ADDR; // RULE_17
                    force_plus_one_ff <= 1'b1;
                    q_r               <= acc_r; // RULE_18
                    acc_r             <= 48'h1; // RULE_19
                    advance_clock_function_ff <= 1'b1; // RULE_21
                    state_r <= ST_CWAIT;
                end
                ST_CWAIT: begin
                    force_plus_one_ff <= 1'b0;
                    if (MEM_DONE) begin
                        xchg_r  <= MEM_RDATA;
                        state_r <= ST_CADD;
                    end
                end
                ST_CADD: begin
                    acc_r   <= acc_r + xchg_r; // RULE_19
                    state_r <= ST_CWR;
                end
                ST_CWR: begin
                    xchg_r      <= acc_r; // RULE_20
                    mem_r.req   <= 1'b1;
                    mem_r.wr    <= 1'b1;
                    mem_r.addr  <= ICS_CLOCK_ADDR; // RULE_20
                    mem_r.wdata <= acc_r; // RULE_20
                    mem_r.wmask <= '1;
                    clock_wait_ff           <= 1'b0; // RULE_22
                    clock_action_request_ff <= 1'b0; // RULE_22
                    clock_request_slave_ff  <= 1'b0; // RULE_22
                    function_37_ff          <= 1'b1; // RULE_22
                    state_r <= ST_CEND;
                end
                ST_CEND: begin
                    if (MEM_DONE) begin
                        acc_r <= q_r; // RULE_18
                        interrupt_or_clock_request_ff <= 1'b0;
                        advance_clock_function_ff <= 1'b0;
                        adv_clock_ff <= 1'b0;
                        state_r <= ST_IDLE;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    assign MEM_REQ           = mem_r;
    assign INTERRUPT_LOCKOUT = interrupt_lockout_ff;
    assign HALF_EXIT         = (state_r == ST_EXIT) && return_jump_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // axi4-lite slave
    assign S_AXI_AWREADY = !aw_got_r && !S_AXI_BVALID;
    assign S_AXI_WREADY  = !w_got_r && !S_AXI_BVALID;
    assign S_AXI_ARREADY = !S_AXI_RVALID;

    always_ff @(posedge CLK) begin
        if (RST) begin
            aw_got_r     <= 1'b0;
            w_got_r      <= 1'b0;
            awaddr_r     <= 8'h00;
            wdata_r      <= 32'h0;
            ctrl_r       <= ICS_CTRL_RST;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP  <= ICS_RESP_OKAY;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_got_r <= 1'b1;
                awaddr_r <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_got_r <= 1'b1;
                wdata_r <= S_AXI_WDATA;
            end
            if (aw_got_r && w_got_r) begin
                aw_got_r     <= 1'b0;
                w_got_r      <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                if (awaddr_r == ICS_REG_CTRL) begin
                    ctrl_r      <= {31'h0, wdata_r[0]};
                    S_AXI_BRESP <= ICS_RESP_OKAY;
                end else begin
                    S_AXI_BRESP <= ICS_RESP_SLVERR;
                end
            end else if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA  <= 32'h0;
            S_AXI_RRESP  <= ICS_RESP_OKAY;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RRESP  <= ICS_RESP_OKAY;
            unique case (S_AXI_ARADDR)
                ICS_REG_CTRL:  S_AXI_RDATA <= ctrl_r;
                ICS_REG_STAT:  S_AXI_RDATA <= {12'h0, 4'(state_r), ext_pend_r,
                                               function_37_ff, advance_clock_function_ff,
                                               force_plus_one_ff, half_word_exit_ff,
                                               internal_request_ff, clock_wait_ff,
                                               clock_request_slave_ff,
                                               clock_action_request_ff,
                                               interrupt_or_clock_request_ff,
                                               return_jump_ff, interrupt_exit_ff,
                                               interrupt_lockout_ff};
                ICS_REG_PADDR: S_AXI_RDATA <= {17'h0, prog_addr_r};
                ICS_REG_ACC:   S_AXI_RDATA <= acc_r[31:0];
                ICS_REG_QREG:  S_AXI_RDATA <= q_r[31:0];
                ICS_REG_INSTR: S_AXI_RDATA <= instruction_holding_reg[31:0];
                ICS_REG_XCHG:  S_AXI_RDATA <= xchg_r[31:0];
                default: begin
                    S_AXI_RDATA <= 32'h0;
                    S_AXI_RRESP <= ICS_RESP_SLVERR;
                end
            endcase
        end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // assertions
    lockout_set_a: assert property (@(posedge CLK) disable iff (RST)
        (state_r == ST_SAVE && !adv_clock_ff) |=> interrupt_lockout_ff) // RULE_05
        else $error("lockout not set");
    trap_range_a: assert property (@(posedge CLK) disable iff (RST)
        (state_r == ST_TRAPR) |-> (prog_addr_r >= ICS_TRAP_BASE && prog_addr_r <= ICS_TRAP_LAST)) // RULE_04
        else $error("trap address out of range");
    trap_read_a: assert property (@(posedge CLK) disable iff (RST)
        (state_r == ST_TRAPR) |=> (mem_r.req && !mem_r.wr && mem_r.addr == $past(prog_addr_r))) // RULE_09
        else $error("trap read missing");
    rjump_set_a: assert property (@(posedge CLK) disable iff (RST)
        (state_r == ST_EXIT) |-> return_jump_ff && !interrupt_or_clock_request_ff) // RULE_11
        else $error("return jump or request wrong");
    save_addr_a: assert property (@(posedge CLK) disable iff (RST)
        (state_r == ST_SAVE) |=> xchg_r[14:0] == $past(prog_addr_r)) // RULE_03
        else $error("address not saved");
    clock_zero_a: assert property (@(posedge CLK) disable iff (RST)
        (state_r == ST_CRD) |=> (mem_r.req && mem_r.addr == ICS_CLOCK_ADDR && q_r == $past(acc_r))) // RULE_17
        else $error("clock read or save wrong");
    clock_sum_a: assert property (@(posedge CLK) disable iff (RST)
        (state_r == ST_CADD) |=> acc_r == $past(xchg_r) + 48'h1) // RULE_19
        else $error("increment wrong");
    clock_end_a: assert property (@(posedge CLK) disable iff (RST)
        (state_r == ST_CWR) |=> (function_37_ff && !clock_wait_ff && !clock_request_slave_ff)) // RULE_22
        else $error("clock end flops wrong");
    exit_copy_a: assert property (@(posedge CLK) disable iff (RST)
        (state_r == ST_SAVE) |=> interrupt_exit_ff == $past(half_word_exit_ff)) // RULE_08
        else $error("exit flop not copied");

endmodule

/* test/ics_mem_model.sv */
// core memory model answering the sequencer
`timescale 1ns/100ps
module ics_mem_model
    import ics_pkg::*;
(
    // clock
    input  wire logic         CLK,
    // request and answer
    input  wire ics_mem_req_s MEM_REQ,
    output logic              MEM_DONE,
    output logic [47:0]       MEM_RDATA
);
    logic [47:0]  mem [0:15];
    logic [14:0]  rd_addr = 15'h0;
    logic [14:0]  wr_addr = 15'h0;
    int           wr_cnt  = 0;
    logic [3:0]   wait_r  = 4'h0;
    ics_mem_req_s cur_r;
    initial MEM_DONE = 1'b0;
    initial MEM_RDATA = 48'h0;
    // writes answer slowly, reads promptly; data toggles when not valid
    always @(posedge CLK) begin
        MEM_DONE <= 1'b0;
        MEM_RDATA <= ~MEM_RDATA;
        if (MEM_REQ.req) begin
            cur_r <= MEM_REQ;
            wait_r <= MEM_REQ.wr ? 4'h4 : 4'h1;
        end else if (wait_r > 4'h1) begin
            wait_r <= wait_r - 4'h1;
        end else if (wait_r == 4'h1) begin
            wait_r <= 4'h0;
            MEM_DONE <= 1'b1;
            if (cur_r.wr) begin
                mem[cur_r.addr[3:0]] <= (mem[cur_r.addr[3:0]] & ~cur_r.wmask)
                                        | (cur_r.wdata & cur_r.wmask);
                wr_addr <= cur_r.addr;
                wr_cnt <= wr_cnt + 1;
            end else begin
                MEM_RDATA <= mem[cur_r.addr[3:0]];
                rd_addr <= cur_r.addr;
            end
        end
    end
endmodule

/* test/interrupt_clock_sequencer_bench.sv */
// self-checking bench for the interrupt and advance-clock sequencer
`timescale 1ns/100ps
module interrupt_clock_sequencer_bench;
    import ics_pkg::*;
    logic         clk = 0, rst = 1, ireq = 0, adv = 0, jmp = 0, srch = 0, fch = 0;
    logic [3:0]   ext = 4'h0;
    logic [7:0]   awaddr = 8'h0, araddr = 8'h0;
    logic [31:0]  wdata = 32'h0, rdata, q, p0;
    logic         awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic         awready, wready, bvalid, arready, rvalid, lock, mdone, hxp;
    logic [1:0]   bresp, rresp, r;
    logic [47:0]  mrd, old;
    ics_mem_req_s mreq;
    int           err_count = 0, samples_checked = 0, cyc = 0, seed = 32015, n, m, hxn = 0;
    always #4 clk = ~clk;
    ics_sequencer uut (.CLK(clk), .RST(rst), .INT_REQ_INTERNAL(ireq),
        .INT_REQ_EXTERNAL(ext), .ADV_CLOCK_REQ(adv), .FETCH_ACTIVE(fch),
        .SEARCH_ACTIVE(srch), .JUMP_TO_TRAP_UPPER(jmp), .MEM_REQ(mreq),
        .MEM_DONE(mdone), .MEM_RDATA(mrd), .INTERRUPT_LOCKOUT(lock), .HALF_EXIT(hxp),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
    ics_mem_model mem_i (.CLK(clk), .MEM_REQ(mreq), .MEM_DONE(mdone), .MEM_RDATA(mrd));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [47:0] upd(input logic [47:0] w, input logic [14:0] p);
        return {w[47:30], p, w[14:0]};
    endfunction
    task automatic summarize;
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    always @(negedge clk) if (hxp === 1'b1) hxn++;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            summarize;
        end
    end
    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic bus(input bit wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rq, output logic [1:0] rr);
        logic ha, hw, hx, hd;
        awaddr <= a;
        araddr <= a;
        wdata <= d;
        awvalid <= wr;
        wvalid <= wr;
        bready <= wr;
        arvalid <= !wr;
        rready <= !wr;
        hd = 0;
        while (!hd) begin
            @(negedge clk);
            ha = awvalid & awready;
            hw = wvalid & wready;
            hx = arvalid & arready;
            hd = wr ? bvalid : rvalid;
            rq = rdata;
            rr = wr ? bresp : rresp;
            @(posedge clk);
            if (ha) awvalid <= 0;
            if (hw) wvalid <= 0;
            if (hx) arvalid <= 0;
        end
        bready <= 0;
        rready <= 0;
        @(posedge clk);
    endtask
    task automatic serve(input logic [14:0] t);
        old = mem_i.mem[t[3:0]];
        m = hxn;
        bus(0, ICS_REG_PADDR, 32'h0, p0, r);
        n = mem_i.wr_cnt;
        while (lock !== 1'b1) @(negedge clk);
        @(posedge clk);
        ireq <= 0;
        ext <= 4'h0;
        while (mem_i.wr_cnt == n) @(negedge clk);
        repeat (3) @(posedge clk);
        chk(mem_i.rd_addr, t);
        chk(mem_i.mem[t[3:0]], upd(old, p0[14:0]));
        chk(lock, 1'b1);
        chk(hxn != m, 1'b1);
        bus(0, ICS_REG_STAT, 32'h0, q, r);
        chk(q[15:12], 4'h0);
        chk(q[8], 1'b1);
        chk(q[1], t != ICS_TRAP_BASE);
        jmp <= 1;
        @(posedge clk);
        jmp <= 0;
        repeat (2) @(posedge clk);
        chk(lock, 1'b0);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        for (int k = 0; k < 16; k++)
            mem_i.mem[k] = 48'({$random(seed), $random(seed)});
        repeat (12) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        bus(0, ICS_REG_STAT, 32'h0, q, r);
        chk({q, r}, {32'h0, ICS_RESP_OKAY});
        bus(0, 8'h1C, 32'h0, q, r);
        chk({q, r}, {32'h0, ICS_RESP_SLVERR});
        bus(1, ICS_REG_PADDR, 32'h5, q, r);
        chk(r, ICS_RESP_SLVERR);
        $display("test registers done");
        ireq <= 1;
        serve(ICS_TRAP_BASE);
        for (int i = 0; i < 4; i++) begin
            srch <= $random(seed);
            fch <= $random(seed);
            ext <= 4'h1 << i;
            serve(15'(9 + 2 * i));
        end
        $display("test interrupts done");
        bus(1, ICS_REG_CTRL, 32'h1, q, r);
        bus(0, ICS_REG_ACC, 32'h0, p0, r);
        old = mem_i.mem[0];
        n = mem_i.wr_cnt;
        adv <= 1;
        repeat (4) @(posedge clk);
        adv <= 0;
        while (mem_i.wr_cnt == n) @(negedge clk);
        repeat (3) @(posedge clk);
        chk({mem_i.rd_addr, mem_i.wr_addr}, {ICS_CLOCK_ADDR, ICS_CLOCK_ADDR});
        chk(mem_i.mem[0], old + 48'h1);
        bus(0, ICS_REG_ACC, 32'h0, q, r);
        chk(q, p0);
        bus(0, ICS_REG_STAT, 32'h0, q, r);
        chk({q[6:4], q[0]}, 4'h0);
        chk(q[8], 1'b0);
        $display("test advance clock done");
        summarize;
    end
endmodule
